// ### logic/spmsp_pkg.sv
// package: register map, field positions and constants for the serial port
package spmsp_pkg;
   // ********************************************************
   // register map (index = printed offset, byte addr = 4*idx)
   // ********************************************************
   localparam logic [7:0] CTRL_IDX = 8'h2C;
   localparam logic [7:0] STAT_IDX = 8'h2D;
   localparam logic [7:0] DATA_IDX = 8'h2E;
   localparam logic [7:0] INTACK_IDX = 8'h2F;
   localparam logic [7:0] PINCFG_IDX = 8'h30;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] STAT_RESET = 8'h00;
   localparam logic [7:0] PINCFG_RESET = 8'h00;
   // ********************************************************
   // control bit positions
   // ********************************************************
   localparam int CTL_IRQEN = 7;
   localparam int CTL_PEN = 6;
   localparam int CTL_LSBF = 5;
   localparam int CTL_MASTER_SELECT_BIT = 4;
   localparam int CTL_CLOCK_POLARITY_BIT = 3;
   localparam int CTL_CLOCK_PHASE_BIT = 2;
   localparam int CTL_RHI = 1;
   localparam int CTL_RLO = 0;
   // ********************************************************
   // status and pin-config bit positions
   // ********************************************************
   localparam int STS_DONE = 7;
   localparam int STS_WRITE_COLLISION_FLAG = 6;
   localparam int STS_DBL = 0;
   localparam int PIN_MISO_OE = 0;
   localparam int PIN_SS_OUT = 1;
   localparam int PIN_SS_VAL = 2;
   localparam int PIN_MOSI_OE = 3;
   localparam int PIN_SCK_OE = 4;
   localparam logic [3:0] BITS_PER_BYTE = 4'd8;
   // ********************************************************
   // master state machine
   // ********************************************************
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_LEAD = 3'b010,
      ST_TRAIL = 3'b100
   } spmsp_state_t;
endpackage : spmsp_pkg

// ### logic/spmsp_port.sv
// serial peripheral port, master or slave, with Avalon-MM register slave
`timescale 1ns/10ps
`default_nettype none
module spmsp_port
   import spmsp_pkg::*;
(
   input  wire logic        core_clk,    // system clock, 25 MHz
   input  wire logic        rst_n,       // async reset, active low
   input  wire logic [9:0]  address,     // avalon byte address
   input  wire logic        read,        // avalon read strobe
   input  wire logic        write,       // avalon write strobe
   input  wire logic [3:0]  byteenable,  // avalon byte lanes
   input  wire logic [31:0] writedata,   // avalon write data
   output logic      [31:0] readdata,    // avalon read data
   output logic             waitrequest, // avalon stall
   input  wire logic        globalIrqEn, // cpu global interrupt enable
   input  wire logic        vectorTaken, // pulse: interrupt vector taken
   output logic             irq,         // interrupt request
   input  wire logic        sckIn,       // clock pin input
   output logic             sckOut,      // clock pin output
   output logic             sckOe_n,     // clock pin enable, low drives
   input  wire logic        mosiIn,      // mosi pin input
   output logic             mosiOut,     // mosi pin output
   output logic             mosiOe_n,    // mosi enable, low drives
   input  wire logic        misoIn,      // miso pin input
   output logic             misoOut,     // miso pin output
   output logic             misoOe_n,    // miso enable, low drives
   input  wire logic        ssIn,        // select pin input
   output logic             ssOut,       // select pin output
   output logic             ssOe_n       // select enable, low drives
);
   // ********************************************************
   // declarations
   // ********************************************************
   logic [7:0]   ctrl_r, pinCfg_r, shift_r, rxBuf_r;
   logic         dbl_r, done_r, write_collision_flag_r, armed_r, ackPend_r;
   logic [3:0]   bitCnt_r;
   logic [6:0]   div_r;
   spmsp_state_t state_r;
   logic         sckPrev_r, sckLvl_r, inBit_r;
   logic         busy, masterMode, slaveSel, sckEdge, leadEdge;
   logic         sampleEdge, shiftEdge, lastTrail, doneEvt, demote;
   logic         rdHit, wrHit, dataAcc, ctrlWr, statRd;
   logic         masterTick, slaveDone;
   logic [6:0]   halfDiv;
   logic [7:0]   idx;
   logic         nextOut;

   // first bit to shift out given order
   function automatic logic outBit(input logic [7:0] v, input logic lsbf);
      outBit = lsbf ? v[0] : v[7];
   endfunction : outBit

   // shift one received bit in at the far end
   function automatic logic [7:0] shiftIn(input logic [7:0] v,
                                          input logic lsbf, input logic b);
      shiftIn = lsbf ? {b, v[7:1]} : {v[6:0], b};
   endfunction : shiftIn

   // ********************************************************
   // bus decode; one-cycle answer, no stall needed
   // ********************************************************
   assign waitrequest = 1'b0;
   assign idx     = address[9:2];
   assign rdHit   = read;
   assign wrHit   = write & byteenable[0];
   assign dataAcc = (rdHit | wrHit) & (idx == DATA_IDX);
   assign ctrlWr  = wrHit & (idx == CTRL_IDX);
   assign statRd  = rdHit & (idx == STAT_IDX);

   // read mux, unmapped reads zero
   always_comb begin
      readdata = 32'h0000_0000;
      unique case (idx)
         CTRL_IDX:   readdata[7:0] = ctrl_r;
         STAT_IDX:   readdata[7:0] = {done_r, write_collision_flag_r, 5'b0_0000, dbl_r};
         DATA_IDX:   readdata[7:0] = rxBuf_r;
         PINCFG_IDX: readdata[7:0] = pinCfg_r;
         default:    readdata = 32'h0000_0000;
      endcase
   end

   // ********************************************************
   // mode and pin control
   // ********************************************************
   assign masterMode = ctrl_r[CTL_PEN] & ctrl_r[CTL_MASTER_SELECT_BIT];
   assign slaveSel   = ctrl_r[CTL_PEN] & ~ctrl_r[CTL_MASTER_SELECT_BIT] & ~ssIn;
   // select as input pulled low while master steals the bus
   assign demote = masterMode & ~pinCfg_r[PIN_SS_OUT] & ~ssIn;
   assign busy   = (state_r != ST_IDLE) | (slaveSel & bitCnt_r != 4'd0);

   assign sckOut   = masterMode ? sckLvl_r : ctrl_r[CTL_CLOCK_POLARITY_BIT];
   assign sckOe_n  = ~(masterMode & pinCfg_r[PIN_SCK_OE]);
   assign mosiOut  = outBit(shift_r, ctrl_r[CTL_LSBF]);
   assign mosiOe_n = ~(masterMode & pinCfg_r[PIN_MOSI_OE]);
   assign misoOut  = outBit(shift_r, ctrl_r[CTL_LSBF]);
   // slave drives miso only when selected and allowed
   assign misoOe_n = ~(slaveSel & pinCfg_r[PIN_MISO_OE]);
   // select as output is a plain port pin, driven only while enabled in master mode
   assign ssOut  = pinCfg_r[PIN_SS_VAL];
   assign ssOe_n = ~(ctrl_r[CTL_PEN] & ctrl_r[CTL_MASTER_SELECT_BIT]
                     & pinCfg_r[PIN_SS_OUT]);
   assign irq = done_r & ctrl_r[CTL_IRQEN] & globalIrqEn;

   // ********************************************************
   // rate select: half-period in system clocks minus one
   // ********************************************************
   always_comb begin
      unique case ({dbl_r, ctrl_r[CTL_RHI], ctrl_r[CTL_RLO]})
         3'b000: halfDiv = 7'd1;
         3'b001: halfDiv = 7'd7;
         3'b010: halfDiv = 7'd31;
         3'b011: halfDiv = 7'd63;
         3'b100: halfDiv = 7'd0;
         3'b101: halfDiv = 7'd3;
         3'b110: halfDiv = 7'd15;
         3'b111: halfDiv = 7'd31;
      endcase
   end
   assign masterTick = (div_r == halfDiv);

   // ********************************************************
   // slave clock edge detect; pins are taken as synchronous
   // ********************************************************
   assign sckEdge    = sckIn ^ sckPrev_r;
   assign leadEdge   = sckIn ^ ctrl_r[CTL_CLOCK_POLARITY_BIT];
   // sample on leading when phase 0, on trailing when phase 1
   assign sampleEdge = sckEdge & (leadEdge ^ ctrl_r[CTL_CLOCK_PHASE_BIT]);
   assign shiftEdge  = sckEdge & ~(leadEdge ^ ctrl_r[CTL_CLOCK_PHASE_BIT]);
   assign slaveDone  = slaveSel & sampleEdge & (bitCnt_r == 4'd7);
   // phase 1 samples on trailing, so its last trailing comes one count early
   assign lastTrail  = ctrl_r[CTL_CLOCK_PHASE_BIT] ? (bitCnt_r == BITS_PER_BYTE - 4'd1)
                                        : (bitCnt_r == BITS_PER_BYTE);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sckPrev_r <= 1'b0;
      end else begin
         sckPrev_r <= sckIn;
      end
   end

   // ********************************************************
   // master sequencer and clock generator
   // ********************************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r  <= ST_IDLE;
         div_r    <= 7'd0;
         sckLvl_r <= 1'b0;
      end else if (!masterMode || demote) begin
         state_r  <= ST_IDLE;
         div_r    <= 7'd0;
         sckLvl_r <= ctrl_r[CTL_CLOCK_POLARITY_BIT];
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               sckLvl_r <= ctrl_r[CTL_CLOCK_POLARITY_BIT];
               div_r    <= 7'd0;
               if (wrHit && idx == DATA_IDX) state_r <= ST_LEAD;
            end
            ST_LEAD: begin
               div_r <= masterTick ? 7'd0 : div_r + 7'd1;
               if (masterTick) begin
                  sckLvl_r <= ~ctrl_r[CTL_CLOCK_POLARITY_BIT];
                  state_r  <= ST_TRAIL;
               end
            end
            ST_TRAIL: begin
               div_r <= masterTick ? 7'd0 : div_r + 7'd1;
               if (masterTick) begin
                  sckLvl_r <= ctrl_r[CTL_CLOCK_POLARITY_BIT];
                  // stop after the eighth trailing edge
                  state_r <= lastTrail ? ST_IDLE : ST_LEAD;
               end
            end
         endcase
      end
   end

   // ********************************************************
   // shift register and bit counter, both roles
   // ********************************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         shift_r  <= 8'h00;
         bitCnt_r <= 4'd0;
         inBit_r  <= 1'b0;
      end else if (masterMode && !demote) begin
         if (state_r == ST_IDLE) begin
            bitCnt_r <= 4'd0;
            if (wrHit && idx == DATA_IDX) shift_r <= writedata[7:0];
         end else if (masterTick) begin
            if ((state_r == ST_LEAD) ^ ctrl_r[CTL_CLOCK_PHASE_BIT]) begin
               inBit_r  <= misoIn;
               bitCnt_r <= bitCnt_r + 4'd1;
            end else if (bitCnt_r != 4'd0) begin
               // mosi moves only on the setup edge, never while sampled
               shift_r <= shiftIn(shift_r, ctrl_r[CTL_LSBF], inBit_r);
            end
         end
      end else if (!slaveSel) begin
         // deselect or disable drops partial byte
         bitCnt_r <= 4'd0;
         if (wrHit && idx == DATA_IDX && ctrl_r[CTL_PEN])
            shift_r <= writedata[7:0];
      end else begin
         if (sampleEdge) begin
            inBit_r  <= mosiIn;
            bitCnt_r <= (bitCnt_r == 4'd7) ? 4'd0 : bitCnt_r + 4'd1;
         end else if (shiftEdge && bitCnt_r != 4'd0)
            shift_r <= shiftIn(shift_r, ctrl_r[CTL_LSBF], inBit_r);
         // colliding write leaves the live byte alone
         if (wrHit && idx == DATA_IDX && !busy && !sampleEdge)
            shift_r <= writedata[7:0];
      end
   end

   // ********************************************************
   // receive buffer: overwritten on each completed byte
   // ********************************************************
   assign doneEvt = (masterMode & ~demote & state_r == ST_TRAIL & masterTick
                     & lastTrail) | slaveDone;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rxBuf_r <= 8'h00;
      end else if (doneEvt) begin
         // unread byte is simply lost, no overrun flag
         rxBuf_r <= slaveDone && !ctrl_r[CTL_CLOCK_PHASE_BIT]
                    ? shiftIn(shift_r, ctrl_r[CTL_LSBF], mosiIn)
                    : (masterMode && !ctrl_r[CTL_CLOCK_PHASE_BIT]
                       ? shiftIn(shift_r, ctrl_r[CTL_LSBF], inBit_r)
                       : (slaveDone
                          ? shiftIn(shift_r, ctrl_r[CTL_LSBF], mosiIn)
                          : shiftIn(shift_r, ctrl_r[CTL_LSBF],
                                    misoIn)));
      end
   end

   // ********************************************************
   // control register, with hardware demotion
   // ********************************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r   <= CTRL_RESET;
         pinCfg_r <= PINCFG_RESET;
         dbl_r    <= 1'b0;
      end else begin
         if (ctrlWr) ctrl_r <= writedata[7:0];
         // demotion wins over a same-cycle write
         if (demote) ctrl_r[CTL_MASTER_SELECT_BIT] <= 1'b0;
         if (wrHit && idx == STAT_IDX) dbl_r <= writedata[STS_DBL];
         if (wrHit && idx == PINCFG_IDX) pinCfg_r <= writedata[7:0];
      end
   end

   // ********************************************************
   // flags: status read arms, data access clears, set wins
   // ********************************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         done_r    <= 1'b0;
         write_collision_flag_r    <= 1'b0;
         armed_r   <= 1'b0;
         ackPend_r <= 1'b0;
      end else begin
         if (statRd) armed_r <= done_r | write_collision_flag_r;
         else if (dataAcc) armed_r <= 1'b0;
         ackPend_r <= 1'b0;
         if ((dataAcc && armed_r) || vectorTaken) done_r <= 1'b0;
         if (dataAcc && armed_r) write_collision_flag_r <= 1'b0;
         if (doneEvt || demote) done_r <= 1'b1;
         if (wrHit && idx == DATA_IDX && busy)
            write_collision_flag_r <= 1'b1;
      end
   end
endmodule : spmsp_port
`default_nettype wire

// ### verif/spmsp_port_assertions.sv
// checker: port-level properties of the serial port
`timescale 1ns/10ps
`default_nettype none
module spmsp_port_chk
   import spmsp_pkg::*;
(
   input wire logic        core_clk,    // system clock
   input wire logic        rst_n,       // reset, active low
   input wire logic [9:0]  address,     // byte address
   input wire logic        read,        // read strobe
   input wire logic        write,       // write strobe
   input wire logic [31:0] readdata,    // read data
   input wire logic        globalIrqEn, // global enable
   input wire logic        vectorTaken, // vector taken
   input wire logic        irq,         // interrupt
   input wire logic        sckOut,      // clock pin
   input wire logic        sckOe_n,     // clock enable
   input wire logic        mosiOe_n,    // mosi enable
   input wire logic        misoOe_n,    // miso enable
   input wire logic        ssIn,        // select pin
   input wire logic        ssOe_n       // select enable
);
   logic [5:0] edgeCnt_r;
   // ********
   // driven clock edges since the last bus write
   // ********
   // any write restarts it, so a polarity change never piles up
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         edgeCnt_r <= 6'h00;
      end else if (write) begin
         edgeCnt_r <= 6'h00;
      end else if ($changed(sckOut) && !sckOe_n) begin
         edgeCnt_r <= edgeCnt_r + 6'h01;
      end
   end
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_statRd;
      read && address == {STAT_IDX, 2'b00};
   endsequence
   // select held low from outside for six cycles while the port leaves it undriven
   sequence s_extSel;
      (!ssIn && ssOe_n) [*6];
   endsequence
   a_resv_zero: assert property (s_statRd |-> readdata[5:1] == 5'h00)
      else $error("reserved status bits set");
   a_upper_zero: assert property (read |-> readdata[31:8] == 24'h0)
      else $error("upper read lanes not zero");
   a_irq_gated: assert property (!globalIrqEn |-> !irq)
      else $error("irq without global enable");
   a_irq_flag: assert property (s_statRd |-> readdata[7] || !irq)
      else $error("irq with done flag clear");
   a_vector_clear: assert property (vectorTaken |=> !irq)
      else $error("irq stays after vector");
   a_miso_quiet: assert property (ssIn [*3] |-> misoOe_n)
      else $error("miso driven while deselected");
   a_demote_pins: assert property (s_extSel |-> sckOe_n && mosiOe_n)
      else $error("clock or mosi driven while selected");
   a_edge_bound: assert property (edgeCnt_r <= 6'h10)
      else $error("more than eight bits clocked");
endmodule : spmsp_port_chk
bind spmsp_port spmsp_port_chk chk_u (.core_clk(core_clk), .rst_n(rst_n),
   .address(address), .read(read), .write(write), .readdata(readdata),
   .globalIrqEn(globalIrqEn), .vectorTaken(vectorTaken), .irq(irq),
   .sckOut(sckOut), .sckOe_n(sckOe_n), .mosiOe_n(mosiOe_n),
   .misoOe_n(misoOe_n), .ssIn(ssIn), .ssOe_n(ssOe_n));
`default_nettype wire

// ### verif/spmsp_slave_model.sv
// partner: behavioural serial slave on the far side of the port
`timescale 1ns/10ps
`default_nettype none
module spmsp_slave_model (
   input  wire logic       sck,    // serial clock
   input  wire logic       mosi,   // data in
   input  wire logic       selN,   // select, active low
   input  wire logic       clock_polarity_bit,   // idle clock level
   input  wire logic       clock_phase_bit,   // clock phase
   input  wire logic       lsbf,   // lsb first
   input  wire logic [7:0] txByte, // byte to send
   output logic            miso,   // data out
   output logic [7:0]      rxByte  // byte taken
);
   logic [7:0] sh;
   // ********
   // shifter
   // ********
   // release shows the inverse, so a stale bit never passes for data
   always @(selN) begin
      sh = txByte;
      miso = (selN === 1'b0) ? (lsbf ? sh[0] : sh[7]) : ~miso;
   end
   // sample edge takes mosi, setup edge moves on a bit
   always @(sck) if (selN === 1'b0) begin
      if ((sck != clock_polarity_bit) != clock_phase_bit) begin
         rxByte = lsbf ? {mosi, rxByte[7:1]} : {rxByte[6:0], mosi};
      end else begin
         if (!clock_phase_bit) sh = lsbf ? sh >> 1 : sh << 1;
         miso = lsbf ? sh[0] : sh[7];
         if (clock_phase_bit) sh = lsbf ? sh >> 1 : sh << 1;
      end
   end
   initial miso = 1'b1;
endmodule : spmsp_slave_model
`default_nettype wire

// ### verif/spmsp_port_tb.sv
// testbench: register, master and slave checks of the serial port
`timescale 1ns/10ps
`default_nettype none
module spmsp_port_tb;
   import spmsp_pkg::*;
   logic        core_clk = 0, rst_n = 0, read = 0, write = 0;
   logic [9:0]  address = 10'h000;
   logic [31:0] writedata = 32'h0, readdata;
   logic        globalIrqEn = 0, vectorTaken = 0, irq, waitrequest;
   logic        sckOut, sckOe_n, mosiOut, mosiOe_n, misoOut, misoOe_n;
   logic        ssOut, ssOe_n, mdlMiso, clock_polarity_bit = 0, clock_phase_bit = 0, lsbf = 0;
   logic        extSck = 0, extMosi = 0, extSs = 1, sckPrev = 0;
   logic [7:0]  mdlTx = 8'h00, mdlRx, got, rdv, cfg;
   int          err_total = 0, checks_done = 0, cyc = 0, edges = 0;
   int          run = 0, halfLen = 0;
   int          divTab[8] = '{4, 16, 64, 128, 2, 8, 32, 64};
   wire         sckW  = sckOe_n ? extSck : sckOut;
   wire         mosiW = mosiOe_n ? extMosi : mosiOut;
   wire         misoW = misoOe_n ? mdlMiso : misoOut;
   wire         ssW   = ssOe_n ? extSs : ssOut;
   spmsp_port dut_u (.core_clk(core_clk), .rst_n(rst_n), .address(address),
      .read(read), .write(write), .byteenable(4'hF), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest),
      .globalIrqEn(globalIrqEn), .vectorTaken(vectorTaken), .irq(irq),
      .sckIn(sckW), .sckOut(sckOut), .sckOe_n(sckOe_n), .mosiIn(mosiW),
      .mosiOut(mosiOut), .mosiOe_n(mosiOe_n), .misoIn(misoW),
      .misoOut(misoOut), .misoOe_n(misoOe_n), .ssIn(ssW), .ssOut(ssOut),
      .ssOe_n(ssOe_n));
   spmsp_slave_model mdl_u (.sck(sckW), .mosi(mosiW), .selN(ssW),
      .clock_polarity_bit(clock_polarity_bit), .clock_phase_bit(clock_phase_bit), .lsbf(lsbf), .txByte(mdlTx),
      .miso(mdlMiso), .rxByte(mdlRx));
   // ********
   // clock, clock-pin monitor, hang guard
   // ********
   always #20 core_clk = ~core_clk;
   // read on the quiet edge so the count never races the design
   always @(negedge core_clk) begin
      run++;
      if (sckOut !== sckPrev && !sckOe_n) begin
         edges++;
         halfLen = run;
         run = 0;
      end
      sckPrev = sckOut;
   end
   // the slowest path is about 3000 cycles
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         complete_run;
      end
   end
   // ********
   // tasks
   // ********
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : chk
   task complete_run;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : complete_run
   task idle(input int n);
      repeat (n) @(posedge core_clk);
   endtask : idle
   // request held until waitrequest is seen low, then one free edge
   task bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
      int n;
      n = 0;
      address <= {idx, 2'b00};
      write <= w;
      read <= !w;
      writedata <= {24'h000000, wd};
      do begin
         @(posedge core_clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      rdv = readdata[7:0];
      read <= 1'b0;
      write <= 1'b0;
      @(posedge core_clk);
   endtask : bus
   task wr(input logic [7:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d);
   endtask : wr
   task rdc(input logic [7:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00);
      chk(rdv, exp);
   endtask : rdc
   task wait_done;
      int n;
      n = 0;
      rdv = 8'h00;
      while (rdv[7] !== 1'b1 && n < 3000) begin
         bus(1'b0, STAT_IDX, 8'h00);
         n++;
      end
   endtask : wait_done
   // partner deselected during setup so a polarity change is no edge
   task mxfer(input logic [7:0] c, input logic [7:0] tx);
      clock_polarity_bit = c[CTL_CLOCK_POLARITY_BIT];
      clock_phase_bit = c[CTL_CLOCK_PHASE_BIT];
      lsbf = c[CTL_LSBF];
      wr(PINCFG_IDX, 8'h1E);
      wr(CTRL_IDX, c);
      wr(PINCFG_IDX, 8'h1A);
      edges = 0;
      wr(DATA_IDX, tx);
   endtask : mxfer
   // outside master, mode 0, msb first, clock at an eighth
   task ext(input logic [7:0] b, input int nb);
      extSs <= 1'b0;
      idle(4);
      for (int k = 7; k > 7 - nb; k--) begin
         extMosi <= b[k];
         idle(4);
         got = {got[6:0], misoW};
         extSck <= 1'b1;
         idle(4);
         extSck <= 1'b0;
      end
      idle(4);
      extSs <= 1'b1;
      extMosi <= ~extMosi;
      idle(4);
   endtask : ext
   // ********
   // tests
   // ********
   initial begin
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      rdc(CTRL_IDX, CTRL_RESET);
      rdc(STAT_IDX, STAT_RESET);
      rdc(INTACK_IDX, 8'h00);
      wr(STAT_IDX, 8'hFE);
      rdc(STAT_IDX, 8'h00);
      $display("test registers done");
      for (int i = 0; i < 8; i++) begin
         cfg = {2'b01, i[0], 1'b1, i[0] ^ i[2], i[1], i[1:0]};
         mdlTx = 8'h1D + 8'(i * 34);
         wr(STAT_IDX, {7'h00, i[2]});
         mxfer(cfg, 8'hB4 ^ 8'(i));
         wait_done;
         chk(edges, 16);
         chk(halfLen, divTab[i] / 2);
         chk(sckOut, cfg[CTL_CLOCK_POLARITY_BIT]);
         chk(mdlRx, 8'hB4 ^ 8'(i));
         rdc(DATA_IDX, mdlTx);
         rdc(STAT_IDX, {7'h00, i[2]});
      end
      $display("test master done");
      wr(STAT_IDX, 8'h00);
      globalIrqEn <= 1'b1;
      mdlTx = 8'h3C;
      mxfer(8'hD0, 8'h96);
      wr(DATA_IDX, 8'h00);
      wait_done;
      chk(edges, 16);
      chk(mdlRx, 8'h96);
      chk(irq, 1'b1);
      globalIrqEn <= 1'b0;
      idle(1);
      chk(irq, 1'b0);
      globalIrqEn <= 1'b1;
      vectorTaken <= 1'b1;
      idle(1);
      vectorTaken <= 1'b0;
      rdc(STAT_IDX, 8'h40);
      rdc(DATA_IDX, 8'h3C);
      rdc(STAT_IDX, 8'h00);
      $display("test collision done");
      wr(PINCFG_IDX, 8'h18);
      wr(CTRL_IDX, 8'h50);
      extSs <= 1'b0;
      idle(8);
      chk(sckOe_n, 1'b1);
      chk(mosiOe_n, 1'b1);
      rdc(CTRL_IDX, 8'h40);
      rdc(STAT_IDX, 8'h80);
      extSs <= 1'b1;
      bus(1'b0, DATA_IDX, 8'h00);
      wr(CTRL_IDX, 8'h50);
      rdc(CTRL_IDX, 8'h50);
      $display("test demotion done");
      wr(PINCFG_IDX, 8'h01);
      wr(CTRL_IDX, 8'h00);
      ext(8'h5A, 8);
      rdc(STAT_IDX, 8'h00);
      wr(CTRL_IDX, 8'h43);
      wr(DATA_IDX, 8'hC3);
      ext(8'h5A, 8);
      chk(got, 8'hC3);
      rdc(STAT_IDX, 8'h80);
      rdc(DATA_IDX, 8'h5A);
      ext(8'hFF, 3);
      ext(8'h69, 8);
      rdc(STAT_IDX, 8'h80);
      rdc(DATA_IDX, 8'h69);
      $display("test slave done");
      complete_run;
   end
endmodule : spmsp_port_tb
`default_nettype wire
